// file: hdl/pm_regs_pkg.sv
`default_nettype none
package pm_regs_pkg;
   // configuration offsets relative to the capability list pointer
   localparam logic [7:0] CAP_OFFSET = 8'h02;
   localparam logic [7:0] CTRL_OFFSET = 8'h04;
   localparam logic [15:0] CAP_RESET = 16'h7601;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   // capability fields
   localparam int CAP_LIGHT_BIT = 9;
   localparam int CAP_PARTIAL_BIT = 10;
   localparam int CAP_WAKE_LSB = 11;
   localparam logic [2:0] REV_SPEC_10 = 3'h1;
   localparam logic [2:0] REV_SPEC_11 = 3'h2;
   // parameter word fields
   localparam int PARAM_LIGHT_BIT = 4;
   localparam int PARAM_PARTIAL_BIT = 5;
   localparam int PARAM_WAKE_LSB = 11;
   // control fields
   localparam int CTRL_ALLOW_BIT = 8;
   localparam int CTRL_SEL_LSB = 9;
   localparam int CTRL_SCALE_LSB = 13;
   localparam int CTRL_FLAG_BIT = 15;
   localparam logic [1:0] SCALE_HUNDREDTH = 2'h2;
   // cycles after reset release before the parameter word is taken
   localparam logic [3:0] LOAD_DELAY = 4'h4;
   typedef enum logic [1:0] {
      LVL_D0 = 2'h0,
      LVL_D1 = 2'h1,
      LVL_D2 = 2'h2,
      LVL_D3 = 2'h3
   } power_level_e;
endpackage
`default_nettype wire

// file: hdl/wake_flag.sv
`timescale 1ns/1ps
`default_nettype none
// sticky flag: set wins over a write-one clear
module wake_flag (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // control
   input wire logic set_pulse,
   input wire logic clear_pulse,
   input wire logic lose_state,
   // state
   output logic flag
);
   typedef struct packed {
      logic flag;
   } state_s;
   state_s st, next_st;
   always_comb begin
      next_st = st;
      if (clear_pulse || lose_state) begin
         next_st.flag = 1'b0;
      end
      if (set_pulse) begin
         next_st.flag = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign flag = st.flag;
   chk_flag_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      set_pulse |=> flag) else $error("wake flag missed a set");
   chk_flag_write_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (clear_pulse && !set_pulse) |=> !flag) else $error("wake flag not cleared");
endmodule
`default_nettype wire

// file: hdl/pci_power_mgmt_regs.sv
// What this block does
// - read-only capability word, 7601h, loaded later
// - revision code in capability bits 2:0
// - light-sleep support bit 9 from param bit 4
// - partial-sleep support bit 10 from param bit 5
// - wake-capable states field in bits 15:11
// - wake states loaded from param word
// - control/status word at offset 4, reads 4000h after reset
// - power level held in control bits 1:0
// - nonzero level blocks io, memory, mastering
// - wake line asserted only when bit 8 set
// - bits 12:9 stored, bits 10:9 select reported consumption state
// - scale bits always read binary 10
// - wake event sets flag bit 15 always
// - writing one clears flag, zero ignored
// - wake source events taken already masked, not gated by wake-report allow
// - full power-down clears allow and select bits, keeps level and flag
`timescale 1ns/1ps
`default_nettype none
module pci_power_mgmt_regs #(
   parameter logic [2:0] SPEC_REVISION = pm_regs_pkg::REV_SPEC_10
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // configuration access, offset relative to the capability pointer
   input wire logic cfg_read,
   input wire logic cfg_write,
   input wire logic [7:0] cfg_offset,
   input wire logic [15:0] cfg_wdata,
   input wire logic [1:0] cfg_byte_en,
   output logic [15:0] cfg_rdata,
   output logic cfg_rvalid,
   // nonvolatile parameter word, valid once loaded
   input wire logic [15:0] nonvolatile_pci_param_word,
   input wire logic param_word_ready,
   // wake sources, already masked by their per-source enables
   input wire logic [3:0] wake_source_events,
   // outputs to the rest of the card
   output logic pme_n_oe,
   output logic io_mem_allowed,
   output logic master_allowed,
   output logic [1:0] device_power_level,
   output logic [1:0] consumption_view_select,
   output logic wake_report_allow
);
   typedef struct packed {
      logic [15:0] cap;
      logic loaded;
      logic [3:0] load_cnt;
      logic [1:0] level;
      logic allow;
      logic [3:0] sel;
      logic [15:0] rdata;
      logic rvalid;
      logic pme_oe;
      logic io_ok;
      logic [1:0] view;
   } state_s;
   state_s st, next_st;
   logic flag;
   logic set_pulse;
   logic clear_pulse;
   logic lose_state;
   logic hit_ctrl_wr;
   logic [15:0] ctrl_word;
   assign hit_ctrl_wr = cfg_write && (cfg_offset == pm_regs_pkg::CTRL_OFFSET);
   // any event sets the flag whatever the allow bit says
   assign set_pulse = |wake_source_events;
   assign clear_pulse = hit_ctrl_wr && cfg_byte_en[1]
      && cfg_wdata[pm_regs_pkg::CTRL_FLAG_BIT];
   // entering D3 clears the allow bit and select bits, not the flag
   assign lose_state = hit_ctrl_wr && cfg_byte_en[0]
      && (cfg_wdata[1:0] == pm_regs_pkg::LVL_D3) && (st.level != pm_regs_pkg::LVL_D3);
   wake_flag u_flag (
      .clk(clk),
      .sys_rst(sys_rst),
      .set_pulse(set_pulse),
      .clear_pulse(clear_pulse),
      .lose_state(1'b0),
      .flag(flag)
   );
   always_comb begin
      ctrl_word = '0;
      ctrl_word[1:0] = st.level;
      ctrl_word[pm_regs_pkg::CTRL_ALLOW_BIT] = st.allow;
      ctrl_word[pm_regs_pkg::CTRL_SEL_LSB +: 4] = st.sel;
      ctrl_word[pm_regs_pkg::CTRL_SCALE_LSB +: 2] = pm_regs_pkg::SCALE_HUNDREDTH;
      ctrl_word[pm_regs_pkg::CTRL_FLAG_BIT] = flag;
   end
   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      // capability load shortly after reset
      if (!st.loaded) begin
         if (st.load_cnt != pm_regs_pkg::LOAD_DELAY) begin
            next_st.load_cnt = st.load_cnt + 4'h1;
         end else if (param_word_ready) begin
            next_st.loaded = 1'b1;
            next_st.cap[2:0] = SPEC_REVISION;
            next_st.cap[pm_regs_pkg::CAP_LIGHT_BIT] =
               nonvolatile_pci_param_word[pm_regs_pkg::PARAM_LIGHT_BIT];
            next_st.cap[pm_regs_pkg::CAP_PARTIAL_BIT] =
               nonvolatile_pci_param_word[pm_regs_pkg::PARAM_PARTIAL_BIT];
            next_st.cap[pm_regs_pkg::CAP_WAKE_LSB +: 5] =
               nonvolatile_pci_param_word[pm_regs_pkg::PARAM_WAKE_LSB +: 5];
         end
      end
      // control writes; capability word ignores writes
      if (hit_ctrl_wr) begin
         if (cfg_byte_en[0]) begin
            next_st.level = cfg_wdata[1:0];
         end
         if (cfg_byte_en[1]) begin
            next_st.allow = cfg_wdata[pm_regs_pkg::CTRL_ALLOW_BIT];
            next_st.sel = cfg_wdata[pm_regs_pkg::CTRL_SEL_LSB +: 4];
         end
         if (lose_state) begin
            next_st.allow = 1'b0;
            next_st.sel = 4'h0;
         end
      end
      if (cfg_read) begin
         next_st.rvalid = 1'b1;
         if (cfg_offset == pm_regs_pkg::CAP_OFFSET) begin
            next_st.rdata = st.cap;
         end else if (cfg_offset == pm_regs_pkg::CTRL_OFFSET) begin
            next_st.rdata = ctrl_word;
         end else begin
            next_st.rdata = 16'h0000;
         end
      end
      next_st.io_ok = (next_st.level == pm_regs_pkg::LVL_D0);
      // line follows the flag value after this edge, only while allowed
      next_st.pme_oe = next_st.allow
         && (set_pulse || (flag && !clear_pulse));
      next_st.view = next_st.sel[1:0];
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
         st.cap <= pm_regs_pkg::CAP_RESET;
         st.io_ok <= 1'b1;
      end else begin
         st <= next_st;
      end
   end
   assign cfg_rdata = st.rdata;
   assign cfg_rvalid = st.rvalid;
   assign pme_n_oe = st.pme_oe;
   assign io_mem_allowed = st.io_ok;
   assign master_allowed = st.io_ok;
   assign device_power_level = st.level;
   assign consumption_view_select = st.view;
   assign wake_report_allow = st.allow;
   // one-edge request shapes shared by the checks below
   sequence ctrl_read_s;
      cfg_read && (cfg_offset == pm_regs_pkg::CTRL_OFFSET);
   endsequence
   sequence cap_load_s;
      !st.loaded && (st.load_cnt == pm_regs_pkg::LOAD_DELAY) && param_word_ready;
   endsequence
   sequence sel_write_s;
      hit_ctrl_wr && cfg_byte_en[1] && !lose_state;
   endsequence
   // access gating by power level
   chk_block_io_sleep: assert property (@(posedge clk) disable iff (sys_rst)
      (device_power_level != 2'h0) |-> !io_mem_allowed && !master_allowed)
      else $error("io allowed while asleep");
   chk_io_at_d0: assert property (@(posedge clk) disable iff (sys_rst)
      (device_power_level == 2'h0) |-> io_mem_allowed && master_allowed)
      else $error("io blocked while awake");
   // wake line
   chk_pme_needs_allow: assert property (@(posedge clk) disable iff (sys_rst)
      pme_n_oe |-> wake_report_allow) else $error("wake line without allow");
   chk_pme_follows: assert property (@(posedge clk) disable iff (sys_rst)
      (flag && st.allow && !clear_pulse && !hit_ctrl_wr) |=> pme_n_oe)
      else $error("wake line not following flag");
   chk_pme_tracks: assert property (@(posedge clk) disable iff (sys_rst)
      pme_n_oe == (wake_report_allow && flag)) else $error("wake line differs from flag");
   chk_allow_write: assert property (@(posedge clk) disable iff (sys_rst)
      sel_write_s |=> wake_report_allow == $past(cfg_wdata[pm_regs_pkg::CTRL_ALLOW_BIT]))
      else $error("allow bit not stored");
   // control word
   chk_scale_reads: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_read_s |=> cfg_rvalid && cfg_rdata[14:13] == 2'h2)
      else $error("scale field wrong");
   chk_flag_read: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_read_s |=> cfg_rdata[15] == $past(flag)) else $error("flag not read back");
   chk_level_write: assert property (@(posedge clk) disable iff (sys_rst)
      (hit_ctrl_wr && cfg_byte_en[0]) |=> device_power_level == $past(cfg_wdata[1:0]))
      else $error("level not stored");
   chk_level_read: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_read_s |=> cfg_rdata[1:0] == $past(device_power_level))
      else $error("level not read back");
   chk_view_select: assert property (@(posedge clk) disable iff (sys_rst)
      sel_write_s |=> consumption_view_select == $past(cfg_wdata[10:9]))
      else $error("consumption view wrong");
   chk_d3_loses: assert property (@(posedge clk) disable iff (sys_rst)
      lose_state |=> !wake_report_allow && st.sel == 4'h0 && consumption_view_select == 2'h0)
      else $error("state kept in D3");
   // capability word
   chk_cap_held: assert property (@(posedge clk) disable iff (sys_rst)
      !st.loaded |-> st.cap == pm_regs_pkg::CAP_RESET) else $error("capability reset lost");
   chk_cap_fixed: assert property (@(posedge clk) disable iff (sys_rst)
      st.loaded |=> $stable(st.cap)) else $error("capability changed");
   chk_rev_code: assert property (@(posedge clk) disable iff (sys_rst)
      st.loaded |-> st.cap[2:0] == SPEC_REVISION) else $error("revision code wrong");
   chk_cap_load: assert property (@(posedge clk) disable iff (sys_rst)
      cap_load_s |=> st.cap[10:9] == $past(nonvolatile_pci_param_word[5:4]))
      else $error("support bits not loaded");
   chk_wake_field: assert property (@(posedge clk) disable iff (sys_rst)
      cap_load_s |=> st.cap[15:11] == $past(nonvolatile_pci_param_word[15:11]))
      else $error("wake states not loaded");
   // read path
   chk_read_answer: assert property (@(posedge clk) disable iff (sys_rst)
      cfg_read |=> cfg_rvalid) else $error("read not answered");
   chk_rvalid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      !cfg_read |=> !cfg_rvalid) else $error("read answer without request");
   chk_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst)
      (cfg_read && cfg_offset != pm_regs_pkg::CAP_OFFSET
      && cfg_offset != pm_regs_pkg::CTRL_OFFSET) |=> cfg_rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

// file: verification/host_pme_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_pme_model (
   // wake line
   input wire logic pme_n_oe,
   output logic pme_line
);
   // pulled up while released
   assign pme_line = pme_n_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// file: verification/pci_power_mgmt_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pci_power_mgmt_regs_tb;
   logic clk, sys_rst, cfg_read, cfg_write, ready, allow, io_ok, mst_ok, rvalid, oe, line;
   logic [7:0] off;
   logic [15:0] wdata, rdata, param, got;
   logic [1:0] be, lvl, view;
   logic [3:0] ev;
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   pci_power_mgmt_regs dut (.clk(clk), .sys_rst(sys_rst), .cfg_read(cfg_read),
      .cfg_write(cfg_write), .cfg_offset(off), .cfg_wdata(wdata), .cfg_byte_en(be),
      .cfg_rdata(rdata), .cfg_rvalid(rvalid), .nonvolatile_pci_param_word(param),
      .param_word_ready(ready), .wake_source_events(ev), .pme_n_oe(oe),
      .io_mem_allowed(io_ok), .master_allowed(mst_ok), .device_power_level(lvl),
      .consumption_view_select(view), .wake_report_allow(allow));
   host_pme_model host (.pme_n_oe(oe), .pme_line(line));
   initial begin clk = 1'b0; forever #20 clk = ~clk; end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] o, input logic [15:0] d);
      off = o;
      wdata = d;
      cfg_write = 1'b1;
      step(1);
      cfg_write = 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [7:0] o);
      off = o;
      cfg_read = 1'b1;
      step(1);
      cfg_read = 1'b0;
      chk("rvalid", 16'h0001, {15'h0, rvalid});
      got = rdata;
      step(1);
   endtask
   task automatic boot(input logic [15:0] p);
      sys_rst = 1'b1;
      ready = 1'b0;
      param = p;
      step(5);
      sys_rst = 1'b0;
   endtask
   task automatic pulse(input logic [3:0] e);
      ev = e;
      step(1);
      ev = 4'h0;
      step(2);
   endtask
   task automatic conclude();
      if (fails == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         conclude();
      end
   end
   initial begin
      {cfg_read, cfg_write, ev, off, wdata} = '0;
      be = 2'h3;
      boot(16'hF810);
      rd(8'h02);
      chk("cap_reset", 16'h7601, got);
      ready = 1'b1;
      step(8);
      rd(8'h02);
      chk("cap_loaded", 16'hFA01, got);
      wr(8'h02, 16'h0000);
      rd(8'h02);
      chk("cap_ro", 16'hFA01, got);
      rd(8'h04);
      chk("ctrl_reset", 16'h0000, got & 16'h9FFF);
      chk("scale", 16'h0002, {14'h0, got[14:13]});
      rd(8'h10);
      chk("unmapped", 16'h0000, got);
      for (int n = 0; n < 4; n++) begin
         wr(8'h04, 16'(n));
         chk("level", 16'(n), {14'h0, lvl});
         chk("access", {14'h0, {2{n == 0}}}, {14'h0, io_ok, mst_ok});
         rd(8'h04);
         chk("level_rd", 16'(n), {14'h0, got[1:0]});
      end
      for (int s = 0; s < 8; s++) begin
         wr(8'h04, 16'h0100 | 16'(s << 9));
         chk("view", 16'(s % 4), {14'h0, view});
         rd(8'h04);
         chk("ctrl_rd", 16'h4100 | 16'(s << 9), got);
      end
      wr(8'h04, 16'h0000);
      pulse(4'h1);
      chk("line_off", 16'h0001, {15'h0, line});
      rd(8'h04);
      chk("flag", 16'h8000, got & 16'h8000);
      wr(8'h04, 16'h0100);
      chk("line_on", 16'h0000, {15'h0, line});
      be = 2'h1;
      wr(8'h04, 16'h8100);
      be = 2'h3;
      wr(8'h04, 16'h0100);
      rd(8'h04);
      chk("flag_kept", 16'hC100, got);
      wr(8'h04, 16'h8100);
      chk("line_rel", 16'h0001, {15'h0, line});
      rd(8'h04);
      chk("flag_clr", 16'h4100, got);
      wr(8'h04, 16'h0B00);
      pulse(4'h8);
      wr(8'h04, 16'h0B03);
      rd(8'h04);
      chk("d3_ctrl", 16'hC003, got);
      chk("d3_view", 16'h0000, {13'h0, allow, view});
      boot(16'h0020);
      ready = 1'b1;
      step(8);
      rd(8'h02);
      chk("cap_alt", 16'h0401, got);
      conclude();
   end
endmodule
`default_nettype wire
